// *** src/ubg_pkg.sv ***
// Constants and types for the serial break-field unit and its baud generator.
// Assumes a single 200 MHz clock; register indices are Avalon-MM word addresses.
package ubg_pkg;

    // Register word indices
    localparam logic [3:0] OFS_MODE  = 4'h0;
    localparam logic [3:0] OFS_CTRL  = 4'h1;
    localparam logic [3:0] OFS_CKSEL = 4'h2;
    localparam logic [3:0] OFS_BAUD  = 4'h3;
    localparam logic [3:0] OFS_TXBUF = 4'h4;
    localparam logic [3:0] OFS_RXBUF = 4'h5;
    localparam logic [3:0] OFS_ERR   = 4'h6;
    localparam logic [3:0] OFS_STAT  = 4'h7;

    // Field positions
    localparam int B_POWER  = 7;
    localparam int B_TXE    = 6;
    localparam int B_RXE    = 5;
    localparam int B_SBRF   = 7;
    localparam int B_SBRT   = 6;
    localparam int B_SBTT   = 5;
    localparam int B_SBL_HI = 4;
    localparam int B_SBL_LO = 2;
    localparam int B_OVE    = 0;
    localparam int B_FE     = 1;
    localparam int B_PE     = 2;
    localparam int B_TXBUSY = 0;
    localparam int B_TXFULL = 1;
    localparam int B_RXFULL = 2;

    // Reset values
    localparam logic [7:0] RST_BAUD  = 8'hff;
    localparam logic [7:0] RST_RXBUF = 8'hff;
    localparam logic [3:0] RST_CKSEL = 4'h0;
    localparam logic [2:0] RST_SBL   = 3'h0;

    // Counts
    localparam logic [3:0] PRE_MAX    = 4'hb;
    localparam logic [4:0] BRK_BASE   = 5'h0d;
    localparam logic [2:0] BRK_OFS    = 3'h3;
    localparam logic [3:0] BRK_RX_MIN = 4'hb;
    localparam logic [3:0] TX_LAST    = 4'h9;
    localparam logic [3:0] RX_LAST    = 4'h8;
    localparam logic [1:0] GAP_TICKS  = 2'h2;

    typedef struct packed {
        logic power;
        logic txe;
        logic rxe;
    } ubg_mode_t;

    typedef enum logic [1:0] {TX_IDLE, TX_FRAME, TX_GAP, TX_BREAK} ubg_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} ubg_rx_st_t;

endpackage

// *** src/ubg_top.sv ***
// Serial unit core: noise filter, break-field transmit/receive, baud generator.
// Assumes one clock, an Avalon-MM master with waitrequest, and a remote node
// on the serial pins.
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Receive input is sampled on the selected prescaler base clock.
// - Filter passes a new level only when two successive samples agree.
// - Internal receive view lags the pin by two base clocks.
// - With power enabled the transmit pin idles high.
// - Writing break-transmit trigger with power and transmit enabled starts a break.
// - Break drives transmit pin low for 13 to 20 bit times per length field.
// - Break end raises transmit-done, clears trigger, returns to normal mode.
// - After a break transmitter idles until new data or a new trigger.
// - Break receive enabled by writing trigger with power and receive enabled.
// - Break receive detects start bit and shifts in like normal reception.
// - Low of 11 bits or more: receive-done, trigger and flag self-clear.
// - Overrun and framing detection suppressed during break reception.
// - Break reception never loads the receive buffer.
// - Low of 10 bits or less: no interrupt, trigger and flag stay set.
// - Base clock reaches counters only with power enabled, else held low.
// - Transmit and receive paths have independent 8-bit counters.
// - Transmit counter held at zero unless power and transmit enabled.
// - Transmit counter clears when first data is written to the buffer.
// - Back-to-back frames clear the counter when the next frame loads, two base clocks after frame end; else it runs on.
// - Receive counter held at zero unless power and receive enabled.
// - Receive counter starts on start bit, stops after one frame.
// - Serial rate is base clock divided by twice the divide value k.
// - Falling edge: count k, resample; low there is a start bit.
// - Back-to-back frames get two extra base clocks between stop and start.
module ubg_top
    import ubg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin,
    output logic             transmit_done_irq,
    output logic             receive_done_irq
);

    ubg_mode_t  mode;
    ubg_tx_st_t tx_state;
    ubg_rx_st_t rx_state;
    logic        ack, req, wr_go, rd_go;
    logic [7:0]  wdat, rd_mux;
    logic [3:0]  clock_select_reg;
    logic [7:0]  baud_divider_reg, kmax;
    logic [2:0]  break_length_field;
    logic        break_transmit_trigger, break_receive_trigger, break_receive_flag;
    logic [7:0]  transmit_buffer, receive_buffer, receive_shifter;
    logic        tx_full, rx_full, overrun_error_flag, framing_error_flag;
    logic [10:0] pre_cnt, pre_mask;
    logic [3:0]  sel_c;
    logic        base_tick, tx_run, rx_run;
    logic [7:0]  tx_cnt, rx_cnt;
    logic        tx_half, rx_half, tx_clr, tx_bit_end;
    logic        tx_load, brk_go, brk_end, frame_end;
    logic [8:0]  transmit_shifter;
    logic [4:0]  tx_bits, brk_len;
    logic [1:0]  gap_cnt;
    logic        rx_meta, rx_sync, filt_smp, filt, filt_d;
    logic        rx_fall, rx_half_pt, rx_samp;
    logic [3:0]  rx_bits, low_cnt;
    logic        rx_norm_end, rx_brk_end, rx_brk_ok;

    // Bus slave: one wait cycle, read data registered in the wait cycle
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack;
    assign wr_go           = avs_write & ack & avs_byteenable[0];
    assign rd_go           = avs_read & ack;
    assign wdat            = avs_writedata[7:0];

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ack <= 1'b0;
        else
            ack <= req & ~ack;
    end

    always_comb
    begin
        rd_mux = 8'h00;
        case (avs_address)
            OFS_MODE:  rd_mux = {mode.power, mode.txe, mode.rxe, 5'h00};
            OFS_CTRL:  rd_mux = {break_receive_flag, break_receive_trigger,
                                 break_transmit_trigger, break_length_field, 2'h0};
            OFS_CKSEL: rd_mux = {4'h0, clock_select_reg};
            OFS_BAUD:  rd_mux = baud_divider_reg;
            OFS_TXBUF: rd_mux = transmit_buffer;
            OFS_RXBUF: rd_mux = receive_buffer;
            OFS_ERR:   rd_mux = {6'h00, framing_error_flag, overrun_error_flag};
            OFS_STAT:  rd_mux = {5'h00, rx_full, tx_full, tx_state != TX_IDLE};
            default:   rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            avs_readdata <= 32'h0;
        else if (avs_read && !ack)
            avs_readdata <= {24'h0, rd_mux};
    end

    // Configuration registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode             <= '0;
            clock_select_reg <= RST_CKSEL;
            baud_divider_reg <= RST_BAUD;
        end
        else if (wr_go)
        begin
            if (avs_address == OFS_MODE)
                mode <= '{power: wdat[B_POWER], txe: wdat[B_TXE], rxe: wdat[B_RXE]};
            if (avs_address == OFS_CKSEL)
                clock_select_reg <= wdat[3:0];
            if (avs_address == OFS_BAUD)
                baud_divider_reg <= wdat;
        end
    end

    // Break triggers: a software set in the same cycle as a hardware clear wins
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            break_length_field     <= RST_SBL;
            break_transmit_trigger <= 1'b0;
            break_receive_trigger  <= 1'b0;
            break_receive_flag     <= 1'b0;
        end
        else
        begin
            if (brk_end)
                break_transmit_trigger <= 1'b0;
            if (rx_brk_ok)
            begin
                break_receive_trigger <= 1'b0;
                break_receive_flag    <= 1'b0;
            end
            if (wr_go && avs_address == OFS_CTRL)
            begin
                break_length_field <= wdat[B_SBL_HI:B_SBL_LO];
                if (wdat[B_SBTT] && tx_run)
                    break_transmit_trigger <= 1'b1;
                if (wdat[B_SBRT] && rx_run)
                begin
                    break_receive_trigger <= 1'b1;
                    break_receive_flag    <= 1'b1;
                end
            end
        end
    end

    // Prescaler: base tick every 2^n clocks, none while powered down
    assign sel_c     = (clock_select_reg > PRE_MAX) ? PRE_MAX : clock_select_reg;
    assign pre_mask  = 11'h7ff >> (PRE_MAX - sel_c);
    assign base_tick = mode.power && ((pre_cnt & pre_mask) == pre_mask);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            pre_cnt <= 11'h0;
        else if (!mode.power)
            pre_cnt <= 11'h0;
        else
            pre_cnt <= pre_cnt + 11'h1;
    end

    // Transmit counter: half-bit every k ticks, so one bit is 2k ticks
    assign tx_run     = mode.power & mode.txe;
    assign kmax       = baud_divider_reg - 8'h01;
    assign tx_bit_end = base_tick && tx_cnt == kmax && tx_half;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_cnt  <= 8'h0;
            tx_half <= 1'b0;
        end
        else if (!tx_run || tx_clr)
        begin
            tx_cnt  <= 8'h0;
            tx_half <= 1'b0;
        end
        else if (base_tick)
        begin
            if (tx_cnt == kmax)
            begin
                tx_cnt  <= 8'h0;
                tx_half <= ~tx_half;
            end
            else
                tx_cnt <= tx_cnt + 8'h01;
        end
    end

    // Transmit control
    assign brk_go    = tx_run && tx_state == TX_IDLE && break_transmit_trigger;
    // The second gap tick starts the next frame, so the stop bit stretches by exactly two ticks
    assign tx_load   = tx_run && tx_full && !brk_go &&
                       (tx_state == TX_IDLE ||
                        (tx_state == TX_GAP && base_tick && gap_cnt == GAP_TICKS - 2'h1));
    assign tx_clr    = tx_load | brk_go;
    assign brk_len   = BRK_BASE + {2'h0, break_length_field + BRK_OFS};
    assign brk_end   = tx_state == TX_BREAK && tx_bit_end && tx_bits == brk_len - 5'h01;
    assign frame_end = tx_state == TX_FRAME && tx_bit_end && tx_bits == {1'b0, TX_LAST};

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_state          <= TX_IDLE;
            serial_out_pin    <= 1'b1;
            transmit_shifter  <= 9'h1ff;
            tx_bits           <= 5'h0;
            gap_cnt           <= 2'h0;
            transmit_done_irq <= 1'b0;
        end
        else
        begin
            transmit_done_irq <= 1'b0;
            if (!tx_run)
            begin
                tx_state       <= TX_IDLE;
                serial_out_pin <= 1'b1;
            end
            else if (tx_load)
            begin
                tx_state         <= TX_FRAME;
                serial_out_pin   <= 1'b0;
                transmit_shifter <= {1'b1, transmit_buffer};
                tx_bits          <= 5'h0;
            end
            else
            begin
                case (tx_state)
                    TX_IDLE:
                    begin
                        serial_out_pin <= ~brk_go;
                        tx_bits        <= 5'h0;
                        if (brk_go)
                            tx_state <= TX_BREAK;
                    end
                    TX_BREAK:
                    begin
                        if (tx_bit_end)
                            tx_bits <= tx_bits + 5'h01;
                        if (brk_end)
                        begin
                            transmit_done_irq <= 1'b1;
                            serial_out_pin    <= 1'b1;
                            tx_state          <= TX_IDLE;
                        end
                    end
                    TX_FRAME:
                    begin
                        if (frame_end)
                        begin
                            transmit_done_irq <= 1'b1;
                            gap_cnt           <= 2'h0;
                            tx_state          <= tx_full ? TX_GAP : TX_IDLE;
                        end
                        else if (tx_bit_end)
                        begin
                            serial_out_pin   <= transmit_shifter[0];
                            transmit_shifter <= {1'b1, transmit_shifter[8:1]};
                            tx_bits          <= tx_bits + 5'h01;
                        end
                    end
                    TX_GAP:
                    begin
                        if (base_tick && gap_cnt != GAP_TICKS)
                            gap_cnt <= gap_cnt + 2'h1;
                    end
                    default: tx_state <= TX_IDLE;
                endcase
            end
        end
    end

    // Transmit buffer; a write in the load cycle is kept as the next frame
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            transmit_buffer <= 8'h0;
            tx_full         <= 1'b0;
        end
        else
        begin
            if (tx_load || !tx_run)
                tx_full <= 1'b0;
            if (wr_go && avs_address == OFS_TXBUF && tx_run)
            begin
                transmit_buffer <= wdat;
                tx_full         <= 1'b1;
            end
        end
    end

    // Pin synchroniser, then the two-sample match filter on the base tick
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end
        else
        begin
            rx_meta <= serial_in_pin;
            rx_sync <= rx_meta;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            filt_smp <= 1'b1;
            filt     <= 1'b1;
            filt_d   <= 1'b1;
        end
        else if (base_tick)
        begin
            filt_smp <= rx_sync;
            if (rx_sync == filt_smp)
                filt <= rx_sync;
            filt_d <= filt;
        end
    end

    // Receive counter: idle and disabled both hold it at zero
    assign rx_run     = mode.power & mode.rxe;
    assign rx_fall    = base_tick && filt_d && !filt;
    assign rx_half_pt = base_tick && rx_cnt == kmax && !rx_half;
    assign rx_samp    = base_tick && rx_cnt == kmax && rx_half;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_cnt  <= 8'h0;
            rx_half <= 1'b0;
        end
        else if (!rx_run || rx_state == RX_IDLE)
        begin
            rx_cnt  <= 8'h0;
            rx_half <= 1'b0;
        end
        else if (base_tick)
        begin
            if (rx_cnt == kmax)
            begin
                rx_cnt  <= 8'h0;
                rx_half <= ~rx_half;
            end
            else
                rx_cnt <= rx_cnt + 8'h01;
        end
    end

    // Break mode runs until the line returns high, counting low bit times
    assign rx_norm_end = rx_state == RX_DATA && rx_samp && !break_receive_trigger &&
                         rx_bits == RX_LAST;
    assign rx_brk_end  = rx_state == RX_DATA && rx_samp && break_receive_trigger && filt;
    assign rx_brk_ok   = rx_brk_end && low_cnt >= BRK_RX_MIN;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_state         <= RX_IDLE;
            rx_bits          <= 4'h0;
            low_cnt          <= 4'h0;
            receive_shifter  <= 8'h0;
            receive_done_irq <= 1'b0;
        end
        else
        begin
            receive_done_irq <= rx_norm_end | rx_brk_ok;
            if (!rx_run)
                rx_state <= RX_IDLE;
            else
            begin
                case (rx_state)
                    RX_IDLE:
                        if (rx_fall)
                            rx_state <= RX_START;
                    RX_START:
                        if (rx_half_pt)
                        begin
                            rx_state <= filt ? RX_IDLE : RX_DATA;
                            rx_bits  <= 4'h0;
                            low_cnt  <= 4'h1;
                        end
                    RX_DATA:
                        if (rx_samp)
                        begin
                            rx_bits <= rx_bits + 4'h1;
                            if (!filt && low_cnt != 4'hf)
                                low_cnt <= low_cnt + 4'h1;
                            if (rx_bits < RX_LAST)
                                receive_shifter <= {filt, receive_shifter[7:1]};
                            if (rx_norm_end || rx_brk_end)
                                rx_state <= RX_IDLE;
                        end
                    default: rx_state <= RX_IDLE;
                endcase
            end
        end
    end

    // Receive buffer and errors; hardware set wins over read-to-clear
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            receive_buffer     <= RST_RXBUF;
            rx_full            <= 1'b0;
            overrun_error_flag <= 1'b0;
            framing_error_flag <= 1'b0;
        end
        else
        begin
            if (rd_go && avs_address == OFS_RXBUF)
                rx_full <= 1'b0;
            if (rd_go && avs_address == OFS_ERR)
            begin
                overrun_error_flag <= 1'b0;
                framing_error_flag <= 1'b0;
            end
            if (rx_norm_end)
            begin
                if (rx_full)
                    overrun_error_flag <= 1'b1;
                else
                begin
                    receive_buffer <= receive_shifter;
                    rx_full        <= 1'b1;
                end
                if (!filt)
                    framing_error_flag <= 1'b1;
            end
        end
    end

    AST_IDLE_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
        mode.power && tx_state == TX_IDLE && !brk_go && !tx_load |=> serial_out_pin)
        else $error("transmit pin not idle high");
    AST_BRK_LOW: assert property (@(posedge clk) disable iff (sys_rst)
        tx_run && tx_state == TX_BREAK |-> !serial_out_pin)
        else $error("transmit pin high during break");
    AST_BRK_END: assert property (@(posedge clk) disable iff (sys_rst)
        brk_end && tx_run |=> transmit_done_irq && tx_state == TX_IDLE)
        else $error("break end without transmit-done");
    AST_BASE_OFF: assert property (@(posedge clk) disable iff (sys_rst)
        !mode.power |-> !base_tick)
        else $error("base clock runs while powered down");
    AST_TXCNT_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        !tx_run |=> tx_cnt == 8'h0 && !tx_half)
        else $error("transmit counter not held");
    AST_RXCNT_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        !rx_run |=> rx_cnt == 8'h0)
        else $error("receive counter not held");
    AST_FILTER: assert property (@(posedge clk) disable iff (sys_rst)
        base_tick && rx_sync != filt_smp |=> $stable(filt))
        else $error("filter passed unmatched sample");
    AST_BRK_NOBUF: assert property (@(posedge clk) disable iff (sys_rst)
        break_receive_trigger && rx_state == RX_DATA |=> $stable(receive_buffer))
        else $error("receive buffer written in break mode");
    AST_BRK_SHORT: assert property (@(posedge clk) disable iff (sys_rst)
        rx_brk_end && low_cnt < BRK_RX_MIN |=> !receive_done_irq && break_receive_flag)
        else $error("short break not ignored");
    AST_BRK_OK: assert property (@(posedge clk) disable iff (sys_rst)
        rx_brk_ok && !(wr_go && avs_address == OFS_CTRL)
        |=> receive_done_irq && !break_receive_trigger && !break_receive_flag)
        else $error("long break not completed");

endmodule

`default_nettype wire

// *** bench/ubg_node.sv ***
// Remote serial node: drives the unit's receive pin.
// Assumes the caller passes the bit time in clocks.
`timescale 1ns/1ps
`default_nettype none
module ubg_node (
    input  wire logic clk,
    output logic      serial_in_pin
);
    // The line is pulled up while the node is quiet
    initial serial_in_pin = 1'b1;

    // Holds the line low for a break, then idles long enough for the stop sample
    task automatic send_low(input int bits, input int bit_clks);
        @(posedge clk);
        serial_in_pin <= 1'b0;
        repeat (bits * bit_clks) @(posedge clk);
        serial_in_pin <= 1'b1;
        repeat (3 * bit_clks) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Testbench: reset values, break transmit and receive, frame timing over Avalon.
// Assumes k=8 and select 0, so one bit lasts 16 clocks.
`timescale 1ns/1ps
`default_nettype none
module tb
    import ubg_pkg::*;
;
    logic        clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic        avs_waitrequest, serial_in_pin, serial_out_pin, transmit_done_irq, receive_done_irq;
    int          n_mismatch = 0, n_checks = 0, seed = 32'h0058f536, n_tx = 0, n_rx = 0, cnt, n0;
    logic [7:0]  q, d;
    logic [9:0]  fr;

    always #2.5 clk = ~clk;
    // Pulses last one cycle, so they are tallied at every edge
    always @(posedge clk)
    begin
        n_tx += (transmit_done_irq === 1'b1);
        n_rx += (receive_done_irq === 1'b1);
    end

    ubg_top dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .transmit_done_irq(transmit_done_irq),
        .receive_done_irq(receive_done_irq));
    ubg_node node (.clk(clk), .serial_in_pin(serial_in_pin));

    function automatic int blen(input int f);
        return (f + 3) % 8 + 13;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic hung();
        n_mismatch++;
        $display("[ERR] %0t timeout", $time);
        results();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] wd);
        int n;
        n = 0;
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= {24'h0, wd};
        do
        begin
            @(posedge clk);
            n++;
            if (n > 20)
                hung();
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_pin(input logic lv);
        cnt = 0;
        while (serial_out_pin !== lv)
        begin
            @(posedge clk);
            cnt++;
            if (cnt > 400)
                hung();
        end
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, OFS_BAUD, 8'h00);
        chk(q, RST_BAUD);
        bus(1'b0, OFS_RXBUF, 8'h00);
        chk(q, RST_RXBUF);
        bus(1'b0, 4'hc, 8'h00);
        chk(avs_readdata, 32'h0);
        bus(1'b1, OFS_BAUD, 8'h08);
        bus(1'b1, OFS_CKSEL, 8'h00);
        bus(1'b1, OFS_MODE, 8'he0);
        chk(serial_out_pin, 1'b1);
        for (int f = 0; f < 8; f++)
        begin
            n0 = n_tx;
            bus(1'b1, OFS_CTRL, {3'b001, f[2:0], 2'b00});
            wait_pin(1'b0);
            wait_pin(1'b1);
            chk(cnt, blen(f) * 16);
            repeat (3) @(posedge clk);
            chk(n_tx, n0 + 1);
            bus(1'b0, OFS_CTRL, 8'h00);
            chk(q[5], 1'b0);
        end
        // Second pass queues a frame behind an all-ones one to see the stretched stop bit
        for (int j = 0; j < 2; j++)
        begin
            d = 8'($random(seed));
            fr = {1'b1, d, 1'b0};
            if (j == 1)
                bus(1'b1, OFS_TXBUF, 8'hff);
            bus(1'b1, OFS_TXBUF, d);
            if (j == 1)
            begin
                wait_pin(1'b1);
                wait_pin(1'b0);
                chk(cnt, 9 * 16 + GAP_TICKS);
            end
            else
                wait_pin(1'b0);
            repeat (8) @(posedge clk);
            for (int i = 0; i < 10; i++)
            begin
                chk(serial_out_pin, fr[i]);
                repeat (16) @(posedge clk);
            end
        end
        n0 = n_rx;
        bus(1'b1, OFS_CTRL, 8'h40);
        node.send_low(9, 16);
        bus(1'b0, OFS_CTRL, 8'h00);
        chk(n_rx, n0);
        chk(q[7:6], 2'b11);
        node.send_low(12, 16);
        bus(1'b0, OFS_CTRL, 8'h00);
        chk(n_rx, n0 + 1);
        chk(q[7:6], 2'b00);
        bus(1'b0, OFS_RXBUF, 8'h00);
        chk(q, RST_RXBUF);
        bus(1'b0, OFS_ERR, 8'h00);
        chk(q, 8'h00);
        results();
    end
endmodule
`default_nettype wire
